//--- rtl/timer_channel_mode_and_value_regs.sv
// Summary of operation
// - Without center PWM and mode select B, mode select A picks capture/compare.
// - Edge/level code 00 releases the pin from the timer entirely.
// - Capture edge: 01 rising, 10 falling, 11 either.
// - Compare match action: 01 toggle, 10 drive low, 11 drive high.
// - Mode select B set gives edge PWM; 10 high-true, X1 low-true.
// - Center PWM select gives center PWM; compare-up clears or sets.
// - Reset clears both value bytes.
// - Capture-mode read latches both bytes until the other byte is read.
// - Status/control write resets read and write latches, debug or not.
// - Value writes are ignored in input capture mode.
// - Debug freezes the read latch state unless status/control is written.
// - Debug reads return the live register, not the buffer.
// - Compare/PWM writes buffer; register loads after both bytes written.
// - With no clock source the second byte write loads at once.
// - Compare mode with clock loads at the next counter change.
// - PWM with clock loads as counter steps from modulo-1 to modulo, or from FFFE to FFFF when modulo is 0.
// - Debug writes go straight into the value register.
// - Debug writes leave a partial buffered sequence intact.
// - Center PWM select forces center PWM on the channel unless edge/level code is 00.
// - Clock source 00 none, 01 bus, 10 fixed, 11 external.
// - Active capture edge copies the counter into the value register.
`timescale 1ns/1ps
module timer_channel_mode_and_value_regs (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic [1:0]          addr,
	input  wire logic [7:0]          wdata,
	input  wire logic                wr,
	input  wire logic                rd,
	output logic      [7:0]          rdata,
	input  wire logic                centerPwmSelect,
	input  wire logic [1:0]          clockSourceSelect,
	input  wire logic                backgroundDebugMode,
	input  wire logic [15:0]         counterValue,
	input  wire logic                counterTick,
	input  wire logic                countDown,
	input  wire logic [15:0]         counterModulo,
	input  wire logic                pinIn,
	output logic                     pinOut,
	output logic                     pinOe_n,
	output logic [15:0]              channelValue,
	output logic                     captureEvent,
	output logic                     compareEvent,
	output tcmvr_pkg::tcmvr_mode_t   channelMode
);
	import tcmvr_pkg::*;

	logic [7:0]  sc_q;
	logic [15:0] value_q;
	logic [15:0] rdBuf_q;
	logic        rdLatched_q;
	logic        rdWaitHigh_q;
	logic [15:0] wrBuf_q;
	logic [15:0] wrBuf_d;
	logic        wrHighDone_q;
	logic        wrLowDone_q;
	logic        loadPending_q;
	logic        pinPrev_q;
	logic        pinOut_q;
	logic [7:0]  rdata_q;
	logic        capEvt_q;
	logic        cmpEvt_q;
	tcmvr_mode_t mode;
	logic [1:0]  els;
	logic        scWrite;
	logic        valWrite;
	logic        valRead;
	logic        isHigh;
	logic        background_debug_mode;
	logic        capMode;
	logic        secondByte;
	logic        loadTrigger;
	logic        loadNow;
	logic        rise;
	logic        fall;
	logic        captureHit;
	logic        match;
	logic        highTrue;

	function automatic tcmvr_mode_t decodeMode(input logic center_aligned_pwm_mode,
		input logic [7:0] sc);
		tcmvr_mode_t m;
		m = MODE_GPIO;
		if (sc[SC_ELS_HI_BIT:SC_ELS_LO_BIT] == ELS_RELEASE) begin
			m = MODE_GPIO;
		end else if (center_aligned_pwm_mode) begin
			m = MODE_CENTER_ALIGNED_PWM_MODE;
		end else if (sc[SC_MSB_BIT]) begin
			m = MODE_EDGE_ALIGNED_PWM_MODE;
		end else if (sc[SC_MSA_BIT]) begin
			m = MODE_COMPARE;
		end else begin
			m = MODE_CAPTURE;
		end
		return m;
	endfunction

	function automatic logic [15:0] preTop(input logic [15:0] modulo);
		return (modulo == FREE_RUN_MODULO) ? FREE_RUN_PRE_TOP :
			16'(modulo - 16'h0001);
	endfunction

	assign mode     = decodeMode(centerPwmSelect, sc_q);
	assign els      = sc_q[SC_ELS_HI_BIT:SC_ELS_LO_BIT];
	assign background_debug_mode      = backgroundDebugMode;
	assign capMode  = (mode == MODE_CAPTURE);
	assign scWrite  = wr && (addr == ADDR_STATUS_CONTROL);
	assign isHigh   = (addr == ADDR_VALUE_HIGH);
	assign valWrite = wr && (isHigh || addr == ADDR_VALUE_LOW);
	assign valRead  = rd && (isHigh || addr == ADDR_VALUE_LOW);
	assign wrBuf_d  = isHigh ? {wdata, wrBuf_q[7:0]} :
		{wrBuf_q[15:8], wdata};
	// Second byte of a buffered pair, outside debug and capture
	assign secondByte = valWrite && !background_debug_mode && !capMode &&
		(isHigh ? wrLowDone_q : wrHighDone_q);
	// Deferred load point depends on clock source and mode
	always_comb begin
		loadTrigger = 1'b0;
		if (clockSourceSelect == CLKS_NONE) begin
			loadTrigger = 1'b1;
		end else if (mode == MODE_EDGE_ALIGNED_PWM_MODE || mode == MODE_CENTER_ALIGNED_PWM_MODE) begin
			loadTrigger = counterTick &&
				(counterValue == preTop(counterModulo));
		end else begin
			loadTrigger = counterTick;
		end
	end
	assign loadNow = loadPending_q && loadTrigger;

	assign rise       = pinIn && !pinPrev_q;
	assign fall       = !pinIn && pinPrev_q;
	assign captureHit = capMode && ((els == ELS_RISE && rise) ||
		(els == ELS_FALL && fall) ||
		(els == ELS_BOTH && (rise || fall)));
	assign match    = counterTick && (counterValue == value_q);
	assign highTrue = (els == ELS_FALL);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sc_q <= SC_RESET;
		end else if (scWrite) begin
			sc_q <= wdata & SC_WRITE_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			value_q <= VALUE_RESET;
		end else if (captureHit) begin
			value_q <= counterValue;
		end else if (valWrite && background_debug_mode && !capMode) begin
			if (isHigh) begin
				value_q[15:8] <= wdata;
			end else begin
				value_q[7:0] <= wdata;
			end
		end else if (secondByte && clockSourceSelect == CLKS_NONE) begin
			value_q <= wrBuf_d;
		end else if (loadNow) begin
			value_q <= wrBuf_q;
		end
	end

	// Write coherency buffer; debug writes leave it untouched
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrBuf_q       <= VALUE_RESET;
			wrHighDone_q  <= 1'b0;
			wrLowDone_q   <= 1'b0;
			loadPending_q <= 1'b0;
		end else if (scWrite) begin
			wrHighDone_q  <= 1'b0;
			wrLowDone_q   <= 1'b0;
			loadPending_q <= 1'b0;
		end else if (valWrite && !background_debug_mode && !capMode) begin
			wrBuf_q <= wrBuf_d;
			// A first byte landing on the load edge must not re-arm it
			if (loadNow) begin
				loadPending_q <= 1'b0;
			end
			if (secondByte) begin
				wrHighDone_q  <= 1'b0;
				wrLowDone_q   <= 1'b0;
				loadPending_q <= (clockSourceSelect != CLKS_NONE);
			end else if (isHigh) begin
				wrHighDone_q <= 1'b1;
			end else begin
				wrLowDone_q <= 1'b1;
			end
		end else if (loadNow && !(valWrite && background_debug_mode)) begin
			// Debug write wins the register, so the load stays pending
			loadPending_q <= 1'b0;
		end
	end

	// Read coherency latch, frozen in debug
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdBuf_q      <= VALUE_RESET;
			rdLatched_q  <= 1'b0;
			rdWaitHigh_q <= 1'b0;
		end else if (scWrite) begin
			rdLatched_q  <= 1'b0;
			rdWaitHigh_q <= 1'b0;
		end else if (valRead && capMode && !background_debug_mode) begin
			if (!rdLatched_q) begin
				rdBuf_q      <= value_q;
				rdLatched_q  <= 1'b1;
				rdWaitHigh_q <= !isHigh;
			end else if (isHigh == rdWaitHigh_q) begin
				rdLatched_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (rd) begin
			case (addr)
				ADDR_STATUS_CONTROL: rdata_q <= sc_q;
				ADDR_VALUE_HIGH: begin
					rdata_q <= (rdLatched_q && capMode && !background_debug_mode) ?
						rdBuf_q[15:8] : value_q[15:8];
				end
				ADDR_VALUE_LOW: begin
					rdata_q <= (rdLatched_q && capMode && !background_debug_mode) ?
						rdBuf_q[7:0] : value_q[7:0];
				end
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinPrev_q <= 1'b0;
		end else begin
			pinPrev_q <= pinIn;
		end
	end

	// Pin action per mode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinOut_q <= 1'b0;
		end else begin
			case (mode)
				MODE_COMPARE: begin
					if (match) begin
						case (els)
							ELS_RISE: pinOut_q <= !pinOut_q;
							ELS_FALL: pinOut_q <= 1'b0;
							default:  pinOut_q <= 1'b1;
						endcase
					end
				end
				MODE_EDGE_ALIGNED_PWM_MODE: begin
					if (match) begin
						pinOut_q <= !highTrue;
					end else if (counterTick && counterValue == COUNT_ZERO) begin
						pinOut_q <= highTrue;
					end
				end
				MODE_CENTER_ALIGNED_PWM_MODE: begin
					if (match) begin
						pinOut_q <= countDown ? highTrue : !highTrue;
					end
				end
				default: pinOut_q <= pinOut_q;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			capEvt_q <= 1'b0;
			cmpEvt_q <= 1'b0;
		end else begin
			capEvt_q <= captureHit;
			cmpEvt_q <= match && !capMode && mode != MODE_GPIO;
		end
	end

	assign rdata        = rdata_q;
	assign pinOut       = pinOut_q;
	assign pinOe_n      = (mode == MODE_GPIO) || capMode;
	assign channelValue = value_q;
	assign captureEvent = capEvt_q;
	assign compareEvent = cmpEvt_q;
	assign channelMode  = mode;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_reset_value: assert property (disable iff (1'b0)
		!rst_n |=> value_q == VALUE_RESET)
		else $error("value not cleared by reset");
	chk_mode_select_a: assert property (
		!centerPwmSelect && !sc_q[SC_MSB_BIT] && els != ELS_RELEASE
		|-> mode == (sc_q[SC_MSA_BIT] ? MODE_COMPARE : MODE_CAPTURE))
		else $error("mode select A decode wrong");
	chk_pin_release: assert property (
		els == ELS_RELEASE |-> pinOe_n && mode == MODE_GPIO)
		else $error("pin not released");
	chk_edge_aligned_pwm_mode_decode: assert property (
		!centerPwmSelect && sc_q[SC_MSB_BIT] && els != ELS_RELEASE
		|-> mode == MODE_EDGE_ALIGNED_PWM_MODE && !pinOe_n)
		else $error("edge PWM not selected");
	chk_center_aligned_pwm_mode_decode: assert property (
		centerPwmSelect && els != ELS_RELEASE |-> mode == MODE_CENTER_ALIGNED_PWM_MODE)
		else $error("center PWM not selected");
	chk_capture_edge: assert property (
		capMode && els == ELS_FALL && rise |=> !capEvt_q)
		else $error("capture on wrong edge");
	chk_capture_copy: assert property (
		captureHit |=> value_q == $past(counterValue) && capEvt_q)
		else $error("capture did not copy counter");
	chk_compare_toggle: assert property (
		mode == MODE_COMPARE && els == ELS_RISE && match
		|=> pinOut_q != $past(pinOut_q))
		else $error("compare toggle missing");
	chk_capture_nowrite: assert property (
		capMode && valWrite && !captureHit |=> $stable(value_q))
		else $error("value written in capture mode");
	chk_sc_clears: assert property (
		scWrite |=> !rdLatched_q && !wrHighDone_q && !wrLowDone_q)
		else $error("latches survive status write");
	chk_debug_freeze: assert property (
		background_debug_mode && !scWrite |=> $stable(rdLatched_q) && $stable(rdBuf_q))
		else $error("read latch moved in debug");
	chk_debug_read: assert property (
		background_debug_mode && rd && isHigh |=> rdata == $past(value_q[15:8]))
		else $error("debug read not live value");
	chk_second_load: assert property (
		secondByte && clockSourceSelect == CLKS_NONE && !captureHit
		|=> value_q == $past(wrBuf_d))
		else $error("immediate load missing");
	chk_debug_write: assert property (
		background_debug_mode && valWrite && !isHigh && !capMode
		|=> value_q[7:0] == $past(wdata) && $stable(wrBuf_q))
		else $error("debug write not direct");

	cov_capture: cover property (captureHit ##1 valRead ##[1:4] valRead);
	cov_deferred: cover property (loadPending_q ##[1:20] loadNow);
	cov_debug_write: cover property (background_debug_mode && valWrite && wrHighDone_q);
	cov_center_aligned_pwm_mode_match: cover property (mode == MODE_CENTER_ALIGNED_PWM_MODE && match);
endmodule

//--- rtl/tcmvr_pkg.sv
package tcmvr_pkg;
	localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_VALUE_HIGH     = 2'h1;
	localparam logic [1:0] ADDR_VALUE_LOW      = 2'h2;
	localparam int         SC_IE_BIT           = 6;
	localparam int         SC_MSB_BIT          = 5;
	localparam int         SC_MSA_BIT          = 4;
	localparam int         SC_ELS_HI_BIT       = 3;
	localparam int         SC_ELS_LO_BIT       = 2;
	localparam logic [7:0] SC_WRITE_MASK       = 8'h7C;
	localparam logic [7:0] SC_RESET            = 8'h00;
	localparam logic [15:0] VALUE_RESET        = 16'h0000;
	localparam logic [15:0] FREE_RUN_MODULO    = 16'h0000;
	localparam logic [15:0] FREE_RUN_PRE_TOP   = 16'hFFFE;
	localparam logic [15:0] COUNT_ZERO         = 16'h0000;
	localparam logic [1:0] CLKS_NONE           = 2'h0;
	localparam logic [1:0] ELS_RELEASE         = 2'h0;
	localparam logic [1:0] ELS_RISE            = 2'h1;
	localparam logic [1:0] ELS_FALL            = 2'h2;
	localparam logic [1:0] ELS_BOTH            = 2'h3;

	typedef enum logic [2:0] {
		MODE_GPIO,
		MODE_CAPTURE,
		MODE_COMPARE,
		MODE_EDGE_ALIGNED_PWM_MODE,
		MODE_CENTER_ALIGNED_PWM_MODE
	} tcmvr_mode_t;
endpackage

//--- dv/tcmvr_pin_model.sv
`timescale 1ns/1ps
module tcmvr_pin_model (
	input  wire logic srcLevel,
	input  wire logic pinOut,
	input  wire logic pinOe_n,
	output logic      pinIn
);
	// Channel drive wins over the external source
	assign pinIn = pinOe_n ? srcLevel : pinOut;
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import tcmvr_pkg::*;
	logic        clk, rst_n, wr, rd, tick, center_aligned_pwm_mode, background_debug_mode, src, pinIn, dn;
	logic        pinOut, pinOe_n, capEvt, cmpEvt;
	logic [1:0]  addr, clks;
	logic [7:0]  wdata, rdata, b;
	logic [15:0] cnt, modV, chVal, expV;
	tcmvr_mode_t mode;
	int          n_errors, tests_run, cycles, nCap, nCmp;

	timer_channel_mode_and_value_regs DUT (.clk(clk), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.centerPwmSelect(center_aligned_pwm_mode), .clockSourceSelect(clks),
		.backgroundDebugMode(background_debug_mode), .counterValue(cnt), .counterTick(tick),
		.countDown(dn), .counterModulo(modV), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe_n(pinOe_n), .channelValue(chVal),
		.captureEvent(capEvt), .compareEvent(cmpEvt), .channelMode(mode));
	tcmvr_pin_model PIN (.srcLevel(src), .pinOut(pinOut),
		.pinOe_n(pinOe_n), .pinIn(pinIn));

	always #20 clk = ~clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string w, input logic [15:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic wrReg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rdReg(input logic [1:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		b = rdata;
	endtask

	task automatic pulse();
		@(posedge clk);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic edgeOn(input logic lvl, input logic [15:0] c);
		@(posedge clk);
		cnt <= c;
		src <= lvl;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic tReset();
		check("value", 16'h0000, chVal);
		check("drive off", 16'h0001, 16'(pinOe_n));
		rdReg(ADDR_VALUE_HIGH);
		check("high byte", 16'h0000, 16'(b));
		rdReg(2'h3);
		check("unmapped", 16'h0000, 16'(b));
		$display("reset test done");
	endtask

	task automatic tModes();
		logic [8:0]  cfg [8];
		tcmvr_mode_t md [8];
		cfg = '{9'h030, 9'h004, 9'h014, 9'h028, 9'h03C, 9'h114, 9'h108,
			9'h100};
		md = '{MODE_GPIO, MODE_CAPTURE, MODE_COMPARE, MODE_EDGE_ALIGNED_PWM_MODE, MODE_EDGE_ALIGNED_PWM_MODE,
			MODE_CENTER_ALIGNED_PWM_MODE, MODE_CENTER_ALIGNED_PWM_MODE, MODE_GPIO};
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			center_aligned_pwm_mode <= cfg[i][8];
			wrReg(ADDR_STATUS_CONTROL, cfg[i][7:0]);
			check("mode", 16'(md[i]), 16'(mode));
			check("oe", 16'(md[i] < MODE_COMPARE), 16'(pinOe_n));
		end
		@(posedge clk);
		center_aligned_pwm_mode <= 1'b0;
		$display("mode test done");
	endtask

	task automatic tWrite();
		@(posedge clk);
		clks <= CLKS_NONE;
		wrReg(ADDR_STATUS_CONTROL, 8'h14);
		wrReg(ADDR_VALUE_HIGH, 8'hA5);
		check("half written", 16'h0000, chVal);
		wrReg(ADDR_VALUE_LOW, 8'h3C);
		check("pair written", 16'hA53C, chVal);
		@(posedge clk);
		clks <= 2'h1;
		wrReg(ADDR_VALUE_LOW, 8'h34);
		wrReg(ADDR_VALUE_HIGH, 8'h12);
		check("load waits", 16'hA53C, chVal);
		pulse();
		check("load on tick", 16'h1234, chVal);
		@(posedge clk);
		modV <= 16'h0010;
		clks <= 2'h2;
		wrReg(ADDR_STATUS_CONTROL, 8'h28);
		wrReg(ADDR_VALUE_HIGH, 8'h00);
		wrReg(ADDR_VALUE_LOW, 8'h08);
		@(posedge clk);
		cnt <= 16'h0005;
		pulse();
		check("pwm waits", 16'h1234, chVal);
		@(posedge clk);
		cnt <= 16'h000F;
		pulse();
		check("pwm loads", 16'h0008, chVal);
		$display("write test done");
	endtask

	task automatic tCompare();
		logic [7:0] els;
		logic [3:0] lv;
		int         c0;
		els = 8'b11_01_01_10;
		lv = 4'b1010;
		@(posedge clk);
		clks <= CLKS_NONE;
		cnt <= 16'h0040;
		wrReg(ADDR_STATUS_CONTROL, 8'h14);
		wrReg(ADDR_VALUE_HIGH, 8'h00);
		wrReg(ADDR_VALUE_LOW, 8'h40);
		c0 = nCmp;
		for (int i = 0; i < 4; i++) begin
			wrReg(ADDR_STATUS_CONTROL, {4'h1, els[7-2*i -: 2], 2'h0});
			pulse();
			check("pin action", 16'(lv[3-i]), 16'(pinOut));
		end
		check("compare events", 16'h0004, 16'(nCmp - c0));
		$display("compare test done");
	endtask

	task automatic tCapture();
		int c0;
		c0 = nCap;
		expV = 16'h0040;
		for (int m = 1; m < 4; m++) begin
			@(posedge clk);
			src <= 1'b0;
			repeat (3) @(posedge clk);
			wrReg(ADDR_STATUS_CONTROL, 8'(m << 2));
			edgeOn(1'b1, 16'h1000 + 16'(m));
			if (m[0]) expV = 16'h1000 + 16'(m);
			check("rise capture", expV, chVal);
			edgeOn(1'b0, 16'h2000 + 16'(m));
			if (m[1]) expV = 16'h2000 + 16'(m);
			check("fall capture", expV, chVal);
		end
		wrReg(ADDR_VALUE_HIGH, 8'hFF);
		wrReg(ADDR_VALUE_LOW, 8'hFF);
		check("capture write", expV, chVal);
		check("capture events", 16'h0004, 16'(nCap - c0));
		$display("capture test done");
	endtask

	task automatic tLatch();
		wrReg(ADDR_STATUS_CONTROL, 8'h0C);
		rdReg(ADDR_VALUE_LOW);
		check("low read", 16'(expV[7:0]), 16'(b));
		edgeOn(1'b1, 16'hBEEF);
		rdReg(ADDR_VALUE_HIGH);
		check("latched high", 16'(expV[15:8]), 16'(b));
		rdReg(ADDR_VALUE_HIGH);
		edgeOn(1'b0, 16'hCAFE);
		wrReg(ADDR_STATUS_CONTROL, 8'h0C);
		rdReg(ADDR_VALUE_LOW);
		check("latch reset", 16'h00FE, 16'(b));
		edgeOn(1'b1, 16'h5A69);
		@(posedge clk);
		background_debug_mode <= 1'b1;
		rdReg(ADDR_VALUE_HIGH);
		check("debug live", 16'h005A, 16'(b));
		@(posedge clk);
		background_debug_mode <= 1'b0;
		rdReg(ADDR_VALUE_HIGH);
		check("frozen latch", 16'h00CA, 16'(b));
		wrReg(ADDR_STATUS_CONTROL, 8'h14);
		wrReg(ADDR_VALUE_HIGH, 8'h11);
		@(posedge clk);
		background_debug_mode <= 1'b1;
		wrReg(ADDR_VALUE_HIGH, 8'h77);
		check("debug write", 16'h7769, chVal);
		@(posedge clk);
		background_debug_mode <= 1'b0;
		wrReg(ADDR_VALUE_LOW, 8'h33);
		check("buffered pair", 16'h1133, chVal);
		$display("latch and debug test done");
	endtask

	task automatic tPwm();
		int c0;
		c0 = nCmp;
		wrReg(ADDR_STATUS_CONTROL, 8'h28);
		wrReg(ADDR_VALUE_HIGH, 8'h00);
		wrReg(ADDR_VALUE_LOW, 8'h20);
		@(posedge clk);
		cnt <= 16'h0000;
		pulse();
		check("edge_aligned_pwm_mode start", 16'h0001, 16'(pinOut));
		@(posedge clk);
		cnt <= 16'h0020;
		pulse();
		check("edge_aligned_pwm_mode match", 16'h0000, 16'(pinOut));
		wrReg(ADDR_STATUS_CONTROL, 8'h24);
		pulse();
		check("edge_aligned_pwm_mode low true", 16'h0001, 16'(pinOut));
		@(posedge clk);
		center_aligned_pwm_mode <= 1'b1;
		wrReg(ADDR_STATUS_CONTROL, 8'h08);
		pulse();
		check("center_aligned_pwm_mode up", 16'h0000, 16'(pinOut));
		@(posedge clk);
		dn <= 1'b1;
		pulse();
		check("center_aligned_pwm_mode down", 16'h0001, 16'(pinOut));
		check("pwm events", 16'h0004, 16'(nCmp - c0));
		@(posedge clk);
		dn <= 1'b0;
		clks <= 2'h3;
		modV <= 16'h0000;
		wrReg(ADDR_VALUE_LOW, 8'h34);
		wrReg(ADDR_VALUE_HIGH, 8'h12);
		@(posedge clk);
		cnt <= 16'hFFFD;
		pulse();
		check("free run waits", 16'h0020, chVal);
		@(posedge clk);
		cnt <= 16'hFFFE;
		pulse();
		check("free run loads", 16'h1234, chVal);
		@(posedge clk);
		center_aligned_pwm_mode <= 1'b0;
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		check("reset clears", 16'h0000, chVal);
		check("reset mode", 16'(MODE_GPIO), 16'(mode));
		$display("pwm and reset test done");
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{wr, rd, tick, center_aligned_pwm_mode, background_debug_mode, src, dn} = 7'h00;
		{addr, clks, wdata, cnt, modV} = 44'h0;
		n_errors = 0;
		tests_run = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		tReset();
		tModes();
		tWrite();
		tCompare();
		tCapture();
		tLatch();
		tPwm();
		stop_test();
	end

	always @(posedge clk) begin
		cycles++;
		if (capEvt === 1'b1) begin
			nCap++;
		end
		if (cmpEvt === 1'b1) begin
			nCmp++;
		end
		if (cycles == 4000) begin
			n_errors++;
			stop_test();
		end
	end
endmodule
